// *** dv/pin_driver.sv ***
// Purpose: Far-side pin model for the capture and count inputs
// Assumes: Bench sets levels just after a rising clock edge
// Notes: Comparator output follows its own bench level
`timescale 1ns/1ps
module pin_driver (
  input wire logic cap_lvl,
  input wire logic cnt_lvl,
  input wire logic acmp_lvl,
  output logic capture_input_pin,
  output logic external_count_pin,
  output logic analog_cmp_in
);
  // ----------------
  // Pin levels
  // ----------------
  assign capture_input_pin = cap_lvl;
  assign external_count_pin = cnt_lvl;
  assign analog_cmp_in = acmp_lvl;
endmodule : pin_driver

// *** dv/test_timer16_capture_compare_regs.sv ***
// Purpose: Self-checking bench for the capture/compare timer
// Assumes: Counter is stopped, or its external count pin is idle, whenever a count is read back
// Notes: Ready and valid sampled at the falling edge, stable until the rise
`timescale 1ns/1ps
module test_timer16_capture_compare_regs;
  import timer16_pkg::*;
  logic sys_clk = 1'b0, resetn = 1'b0, cap_lvl = 1'b1, cnt_lvl = 1'b0, acmp_lvl = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic capture_input_pin, analog_cmp_in, external_count_pin;
  irq_lines_t irq_ack = 4'h0, irq_req;
  wave_pins_t wave_pins;
  int err_count = 0, checks = 0, cyc = 0;
  // ----------------
  // Clock, timeout, instances
  // ----------------
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      end_sim();
    end
  end
  timer16_capture_compare_regs dut_u (.sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .capture_input_pin, .analog_cmp_in,
    .external_count_pin, .irq_ack, .irq_req, .wave_pins);
  pin_driver pins_u (.cap_lvl, .cnt_lvl, .acmp_lvl, .capture_input_pin, .external_count_pin,
    .analog_cmp_in);
  // ----------------
  // Bus tasks and compare
  // ----------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w)
    begin
      @(negedge sys_clk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      @(posedge sys_clk);
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(negedge sys_clk); while (!s_axi_bvalid);
    @(posedge sys_clk);
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge sys_clk); while (!s_axi_arready);
    @(posedge sys_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge sys_clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge sys_clk);
  endtask : rd_reg
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      $display("ERROR %0t got %h want %h", $time, g, e);
      err_count++;
    end
  endtask : cmp
  task automatic ck(input logic [7:0] a, input logic [7:0] e);
    rd_reg(a);
    cmp(rd, {24'h000000, e});
  endtask : ck
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_regs;
    logic [7:0] regs [5] = '{OFF_CTRL_B, OFF_CTRL_C, OFF_PIN_EN, OFF_IRQ_MASK, OFF_IRQ_FLAGS};
    foreach (regs[i])
      ck(regs[i], 8'h00);
    wr(OFF_IRQ_MASK, 8'hFF);
    ck(OFF_IRQ_MASK, 8'h27);
    wr(OFF_PIN_EN, 8'hA5);
    cmp(wave_pins[9:2], 8'hA5);
    rd_reg(8'h3C);
    cmp(rr, RESP_SLVERR);
  endtask : t_regs
  task automatic t_latch;
    wr(OFF_CMP_A_H, 8'h00);
    wr(OFF_CMP_A_L, 8'h20);
    wr(OFF_CNT_H, 8'hAB);
    wr(OFF_CNT_L, 8'hCD);
    ck(OFF_CNT_L, 8'hCD);
    ck(OFF_CNT_H, 8'hAB);
    wr(OFF_CMP_B_H, 8'h77);
    ck(OFF_CNT_H, 8'h77);
    ck(OFF_CMP_A_L, 8'h20);
  endtask : t_latch
  task automatic t_match;
    wr(OFF_CNT_H, 8'h00);
    wr(OFF_CNT_L, 8'h00);
    wr(OFF_IRQ_MASK, 8'h02);
    wr(OFF_CTRL_A, 8'h50);
    wr(OFF_CTRL_C, 8'hC0);
    cmp(wave_pins[1:0], 2'h3);
    ck(OFF_CTRL_C, 8'h00);
    ck(OFF_IRQ_FLAGS, 8'h00);
    wr(OFF_CTRL_B, 8'h01);
    repeat (40)
      if (!rd[IRQ_A])
        rd_reg(OFF_IRQ_FLAGS);
    cmp(rd[IRQ_A], 1'b1);
    cmp(irq_req, 4'h0);
    cmp(wave_pins.wave_a, 1'b0);
    wr(OFF_MISC, 8'h01);
    cmp(irq_req, 4'h2);
    irq_ack.match_a <= 1'b1;
    @(posedge sys_clk);
    irq_ack.match_a <= 1'b0;
    ck(OFF_IRQ_FLAGS, 8'h00);
  endtask : t_match
  task automatic t_capture;
    wr(OFF_CTRL_B, 8'h40);
    wr(OFF_CNT_H, 8'h01);
    wr(OFF_CNT_L, 8'h00);
    cap_lvl <= 1'b0;
    repeat (8) @(posedge sys_clk);
    ck(OFF_IRQ_FLAGS, 8'h00);
    cap_lvl <= 1'b1;
    repeat (8) @(posedge sys_clk);
    ck(OFF_IRQ_FLAGS, 8'h20);
    ck(OFF_CAP_L, 8'h00);
    ck(OFF_CAP_H, 8'h01);
    wr(OFF_IRQ_FLAGS, 8'h20);
    ck(OFF_IRQ_FLAGS, 8'h00);
    wr(OFF_CTRL_B, 8'h00);
    cap_lvl <= 1'b0;
    repeat (8) @(posedge sys_clk);
    ck(OFF_IRQ_FLAGS, 8'h20);
  endtask : t_capture
  task automatic t_ext;
    wr(OFF_CTRL_B, 8'h07);
    repeat (6)
    begin
      cnt_lvl <= ~cnt_lvl;
      repeat (4) @(posedge sys_clk);
    end
    ck(OFF_CNT_L, 8'h03);
    wr(OFF_CTRL_B, 8'h06);
    repeat (2)
    begin
      cnt_lvl <= ~cnt_lvl;
      repeat (4) @(posedge sys_clk);
    end
    ck(OFF_CNT_L, 8'h04);
  endtask : t_ext
  task automatic t_top;
    wr(OFF_CTRL_B, 8'h18);
    wr(OFF_IRQ_FLAGS, 8'h27);
    cap_lvl <= 1'b1;
    repeat (8) @(posedge sys_clk);
    cap_lvl <= 1'b0;
    repeat (8) @(posedge sys_clk);
    ck(OFF_IRQ_FLAGS, 8'h00);
    wr(OFF_CAP_H, 8'h00);
    wr(OFF_CAP_L, 8'h05);
    wr(OFF_CNT_L, 8'h00);
    wr(OFF_CTRL_B, 8'h19);
    repeat (12) @(posedge sys_clk);
    ck(OFF_IRQ_FLAGS, 8'h24);
    wr(OFF_CTRL_B, 8'h00);
  endtask : t_top
  task automatic t_filter;
    wr(OFF_CTRL_B, 8'hC0);
    wr(OFF_IRQ_FLAGS, 8'h27);
    cap_lvl <= 1'b1;
    repeat (2) @(posedge sys_clk);
    cap_lvl <= 1'b0;
    repeat (10) @(posedge sys_clk);
    ck(OFF_IRQ_FLAGS, 8'h00);
    cap_lvl <= 1'b1;
    repeat (10) @(posedge sys_clk);
    ck(OFF_IRQ_FLAGS, 8'h20);
    wr(OFF_MISC, 8'h03);
    wr(OFF_CTRL_B, 8'h40);
    wr(OFF_IRQ_FLAGS, 8'h27);
    acmp_lvl <= 1'b1;
    repeat (8) @(posedge sys_clk);
    ck(OFF_IRQ_FLAGS, 8'h20);
  endtask : t_filter
  task automatic t_div;
    wr(OFF_CTRL_A, 8'h51);
    wr(OFF_CTRL_C, 8'h00);
    wr(OFF_CNT_L, 8'h00);
    wr(OFF_CTRL_B, 8'h02);
    repeat (80) @(posedge sys_clk);
    wr(OFF_CTRL_B, 8'h00);
    rd_reg(OFF_CNT_L);
    checks++;
    if (rd !== 32'h0000_000A && rd !== 32'h0000_000B)
    begin
      $display("ERROR %0t divide by 8 count %h", $time, rd);
      err_count++;
    end
  endtask : t_div
  task automatic end_sim;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    t_regs();
    t_latch();
    t_match();
    t_capture();
    t_ext();
    t_top();
    t_filter();
    t_div();
    end_sim();
  end
endmodule : test_timer16_capture_compare_regs

// *** hw/timer16_capture_compare_regs.sv ***
// Purpose: 16-bit timer/counter with capture, compare and interrupt flags
// Assumes: AXI4-Lite master, one write and one read in flight at most
// Notes: Byte registers in lane 0; 16-bit values go through one shared latch
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module timer16_capture_compare_regs
  import timer16_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [timer16_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [timer16_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic capture_input_pin,
  input wire logic analog_cmp_in,
  input wire logic external_count_pin,
  input wire timer16_pkg::irq_lines_t irq_ack,
  output timer16_pkg::irq_lines_t irq_req,
  output timer16_pkg::wave_pins_t wave_pins
);
  import timer16_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] ctrl_a_q, ctrl_b_q, pin_en_q, mask_q, flags_q, misc_q, temp_q;
  logic [15:0] cnt_q, cap_q;
  logic [15:0] ocr_q [2];
  logic [PRE_W-1:0] pre_q;
  logic dir_up_q, block_q;
  logic [1:0] wave_q;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_byte_q, rd_byte;
  logic w_lane_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic rd_ctrl_c_q;

  wire wr_fire = aw_have_q && w_have_q;
  wire rd_fire = s_axi_arvalid && !rvalid_q;
  wire [7:0] wa = {aw_addr_q[ADDR_W-1:2], 2'b00};
  wire [7:0] ra = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  wire wr_ok = (wa <= OFF_MISC);
  wire rd_ok = (ra <= OFF_MISC);
  wire wr_en = wr_fire && w_lane_q && wr_ok;
  wire [7:0] wd = w_byte_q;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      aw_addr_q <= '0;
      w_byte_q <= REG_RESET;
      w_lane_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_byte_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
      rd_ctrl_c_q <= 1'b0;
    end
    else if (rd_fire)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      rd_ctrl_c_q <= (ra == OFF_CTRL_C);
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // mode decode
  wire [3:0] wgm = {ctrl_b_q[WGM_HI_LSB+1:WGM_HI_LSB], ctrl_a_q[1:0]};
  wire mode_normal = (wgm == 4'd0) || (wgm == 4'd13);
  wire mode_ctc = (wgm == 4'd4) || (wgm == 4'd12);
  wire mode_fast = (wgm inside {4'd5, 4'd6, 4'd7, 4'd14, 4'd15});
  wire mode_phase = !mode_normal && !mode_ctc && !mode_fast;
  wire icr_top = (wgm inside {4'd8, 4'd10, 4'd12, 4'd14});
  wire is_pwm = mode_fast || mode_phase;
  logic [15:0] top;

  always_comb
  begin
    unique case (wgm)
      4'd1, 4'd5: top = TOP_8BIT;
      4'd2, 4'd6: top = TOP_9BIT;
      4'd3, 4'd7: top = TOP_10BIT;
      4'd4, 4'd9, 4'd11, 4'd15: top = ocr_q[0];
      4'd8, 4'd10, 4'd12, 4'd14: top = cap_q;
      default: top = TOP_MAX;
    endcase
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and clock select
  // ----------------------------------------------------------------
  logic cap_s1_q, cap_s2_q, acmp_s1_q, acmp_s2_q, ext_s1_q, ext_s2_q, ext_s3_q;

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      {cap_s1_q, cap_s2_q, acmp_s1_q, acmp_s2_q, ext_s1_q, ext_s2_q, ext_s3_q} <= 7'h00;
      pre_q <= '0;
    end
    else
    begin
      {cap_s2_q, cap_s1_q} <= {cap_s1_q, capture_input_pin};
      {acmp_s2_q, acmp_s1_q} <= {acmp_s1_q, analog_cmp_in};
      {ext_s3_q, ext_s2_q, ext_s1_q} <= {ext_s2_q, ext_s1_q, external_count_pin};
      pre_q <= pre_q + 1'b1;
    end
  end

  wire ext_rise = ext_s2_q && !ext_s3_q;
  wire ext_fall = !ext_s2_q && ext_s3_q;
  wire [PRE_W-1:0] m8 = PRE_W'(DIV_8 - 1);
  wire [PRE_W-1:0] m64 = PRE_W'(DIV_64 - 1);
  wire [PRE_W-1:0] m256 = PRE_W'(DIV_256 - 1);
  wire [PRE_W-1:0] m1024 = PRE_W'(DIV_1024 - 1);
  clock_source_sel_t cs;
  logic tick;
  assign cs = clock_source_sel_t'(ctrl_b_q[2:0]);

  always_comb
  begin
    unique case (cs)
      CS_STOP: tick = 1'b0;
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = ((pre_q & m8) == m8);
      CS_DIV64: tick = ((pre_q & m64) == m64);
      CS_DIV256: tick = ((pre_q & m256) == m256);
      CS_DIV1024: tick = ((pre_q & m1024) == m1024);
      CS_EXT_FALL: tick = ext_fall;
      CS_EXT_RISE: tick = ext_rise;
    endcase
  end

  // ----------------------------------------------------------------
  // Capture path
  // ----------------------------------------------------------------
  logic [FILTER_SAMPLES-1:0] hist_q;
  logic filt_q, cap_prev_q;
  wire cap_src = misc_q[MISC_ACMP_BIT] ? acmp_s2_q : cap_s2_q;
  wire cap_in = ctrl_b_q[NOISE_BIT] ? filt_q : cap_src;
  wire cap_edge = ctrl_b_q[EDGE_BIT] ? (cap_in && !cap_prev_q) : (!cap_in && cap_prev_q);
  wire cap_trig = cap_edge && !icr_top;

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      hist_q <= '0;
      filt_q <= 1'b0;
      cap_prev_q <= 1'b0;
    end
    else
    begin
      hist_q <= {hist_q[FILTER_SAMPLES-2:0], cap_src};
      if (&hist_q)
        filt_q <= 1'b1;
      else if (~|hist_q)
        filt_q <= 1'b0;
      cap_prev_q <= cap_in;
    end
  end

  // ----------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------
  logic [1:0] match, force_w, wave_d;
  wire top_hit = tick && (cnt_q == top);
  compare_output_action_t com [2];
  assign com[0] = compare_output_action_t'(ctrl_a_q[COM_A_LSB+1:COM_A_LSB]);
  assign com[1] = compare_output_action_t'(ctrl_a_q[COM_B_LSB+1:COM_B_LSB]);

  function automatic logic wave_step(input compare_output_action_t act, input logic cur,
                                     input logic chan_a, input logic on_match, input logic frc);
    logic nxt;
    nxt = cur;
    if ((on_match && !is_pwm) || frc)
    begin
      unique case (act)
        COM_TOGGLE: nxt = !cur;
        COM_CLEAR: nxt = 1'b0;
        COM_SET: nxt = 1'b1;
        COM_OFF: nxt = cur;
      endcase
    end
    else if (on_match)
    begin
      if (act == COM_TOGGLE)
        nxt = (wgm[3] && chan_a) ? !cur : cur;
      else if (act != COM_OFF)
        nxt = mode_fast ? (act == COM_SET) : ((act == COM_SET) == dir_up_q);
    end
    else if (top_hit && mode_fast && act[1])
      nxt = (act == COM_CLEAR);
    return nxt;
  endfunction : wave_step

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chan
    assign match[ch] = tick && (cnt_q == ocr_q[ch]) && !block_q;
    assign force_w[ch] = wr_en && (wa == OFF_CTRL_C) && !is_pwm &&
                         wd[ch == 0 ? FORCE_A_BIT : FORCE_B_BIT];
    assign wave_d[ch] = wave_step(com[ch], wave_q[ch], ch == 0, match[ch], force_w[ch]);
  end

  assign wave_pins = '{out_pin_en_b: pin_en_q[7:4], out_pin_en_a: pin_en_q[3:0],
                       wave_b: wave_q[1], wave_a: wave_q[0]};

  // ----------------------------------------------------------------
  // Counter, flags and software registers
  // ----------------------------------------------------------------
  wire cnt_wr = wr_en && (wa == OFF_CNT_L);
  logic [15:0] cnt_d;
  logic dir_d;

  always_comb
  begin
    cnt_d = cnt_q;
    dir_d = dir_up_q;
    if (mode_phase)
    begin
      if (dir_up_q && cnt_q == top)
      begin
        dir_d = 1'b0;
        cnt_d = cnt_q - 16'h0001;
      end
      else if (!dir_up_q && cnt_q == WIDE_RESET)
      begin
        dir_d = 1'b1;
        cnt_d = cnt_q + 16'h0001;
      end
      else
        cnt_d = dir_up_q ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
    end
    else if ((mode_ctc || mode_fast) && cnt_q == top)
      cnt_d = WIDE_RESET;
    else
      cnt_d = cnt_q + 16'h0001;
  end

  wire ovf_set = tick && (mode_phase ? (!dir_up_q && cnt_q == WIDE_RESET) :
                 mode_fast ? (cnt_q == top) : (cnt_q == TOP_MAX));
  wire cap_set = cap_trig || (icr_top && top_hit);
  wire [7:0] flag_set = {2'b00, cap_set, 2'b00, match[1], match[0], ovf_set};
  wire [7:0] flag_clr = ({2'b00, irq_ack.capture, 2'b00, irq_ack.match_b, irq_ack.match_a,
                          irq_ack.overflow}) | ((wr_en && wa == OFF_IRQ_FLAGS) ? wd : 8'h00);
  wire rd_lo = rd_fire && (ra inside {OFF_CNT_L, OFF_CMP_A_L, OFF_CMP_B_L, OFF_CAP_L});
  wire wr_hi = wr_en && (wa inside {OFF_CNT_H, OFF_CMP_A_H, OFF_CMP_B_H, OFF_CAP_H});

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      cnt_q <= WIDE_RESET;
      dir_up_q <= 1'b1;
      block_q <= 1'b0;
      wave_q <= 2'b00;
      flags_q <= REG_RESET;
    end
    else
    begin
      wave_q <= wave_d;
      // Set wins over a same-cycle clear, so no event is lost
      flags_q <= ((flags_q & ~flag_clr) | flag_set) & IRQ_MASK_BITS;
      if (cnt_wr)
      begin
        cnt_q <= {temp_q, wd};
        block_q <= 1'b1;
      end
      else if (tick)
      begin
        cnt_q <= cnt_d;
        dir_up_q <= dir_d;
        block_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      {ctrl_a_q, ctrl_b_q, pin_en_q, mask_q, misc_q, temp_q} <= {6{REG_RESET}};
      ocr_q[0] <= WIDE_RESET;
      ocr_q[1] <= WIDE_RESET;
      cap_q <= WIDE_RESET;
    end
    else
    begin
      if (cap_trig)
        cap_q <= cnt_q;
      if (wr_hi)
        temp_q <= wd;
      else if (rd_lo)
        temp_q <= (ra == OFF_CNT_L) ? cnt_q[15:8] : (ra == OFF_CMP_A_L) ? ocr_q[0][15:8] :
                  (ra == OFF_CMP_B_L) ? ocr_q[1][15:8] : cap_q[15:8];
      if (wr_en)
      begin
        unique case (wa)
          OFF_CTRL_A: ctrl_a_q <= wd & CTRL_A_MASK;
          OFF_CTRL_B: ctrl_b_q <= wd & CTRL_B_MASK;
          OFF_PIN_EN: pin_en_q <= wd;
          OFF_CMP_A_L: ocr_q[0] <= {temp_q, wd};
          OFF_CMP_B_L: ocr_q[1] <= {temp_q, wd};
          OFF_CAP_L: cap_q <= {temp_q, wd};
          OFF_IRQ_MASK: mask_q <= wd & IRQ_MASK_BITS;
          OFF_MISC: misc_q <= wd & MISC_MASK;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux and interrupt lines
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (ra)
      OFF_CTRL_A: rd_byte = ctrl_a_q;
      OFF_CTRL_B: rd_byte = ctrl_b_q;
      OFF_CTRL_C: rd_byte = 8'h00;
      OFF_PIN_EN: rd_byte = pin_en_q;
      OFF_CNT_L: rd_byte = cnt_q[7:0];
      OFF_CMP_A_L: rd_byte = ocr_q[0][7:0];
      OFF_CMP_B_L: rd_byte = ocr_q[1][7:0];
      OFF_CAP_L: rd_byte = cap_q[7:0];
      OFF_CNT_H, OFF_CMP_A_H, OFF_CMP_B_H, OFF_CAP_H: rd_byte = temp_q;
      OFF_IRQ_MASK: rd_byte = mask_q;
      OFF_IRQ_FLAGS: rd_byte = flags_q;
      OFF_MISC: rd_byte = misc_q;
      default: rd_byte = 8'h00;
    endcase
  end

  wire gie = misc_q[MISC_GIE_BIT];
  assign irq_req = '{capture: gie && mask_q[IRQ_CAP] && flags_q[IRQ_CAP],
                     match_b: gie && mask_q[IRQ_B] && flags_q[IRQ_B],
                     match_a: gie && mask_q[IRQ_A] && flags_q[IRQ_A],
                     overflow: gie && mask_q[IRQ_OVF] && flags_q[IRQ_OVF]};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence seq_cap_hit;
    cap_trig && !(wr_en && wa == OFF_CAP_L);
  endsequence
  sequence seq_cap_done;
    (cap_q == $past(cnt_q)) && flags_q[IRQ_CAP];
  endsequence

  AST_FILTER_FOUR: assert property (
    ctrl_b_q[NOISE_BIT] && $rose(filt_q) |-> $past(hist_q) == 4'hF)
    else $error("filter output rose without four high samples");
  AST_EDGE_RISE: assert property (
    ctrl_b_q[EDGE_BIT] && cap_trig |-> cap_in && !$past(cap_in))
    else $error("capture edge not rising with edge select one");
  AST_CAPTURE_COPY: assert property (
    seq_cap_hit |=> seq_cap_done)
    else $error("capture did not copy counter or set flag");
  AST_NO_CAP_AT_TOP: assert property (
    icr_top && !(wr_en && wa == OFF_CAP_L) |=> $stable(cap_q))
    else $error("capture fired while capture value is top");
  AST_DIV1_TICKS: assert property (
    mode_normal && cs == CS_DIV1 && !cnt_wr |=> cnt_q != $past(cnt_q))
    else $error("undivided clock did not advance counter");
  AST_FORCE_KEEPS_CNT: assert property (
    force_w[0] && !tick |=> cnt_q == $past(cnt_q) && !$rose(flags_q[IRQ_A]))
    else $error("forced match moved counter or set flag");
  AST_FORCE_READ_ZERO: assert property (
    rvalid_q && rd_ctrl_c_q |-> rdata_q == 32'h0000_0000)
    else $error("force register read nonzero");
  AST_WRITE_BLOCKS: assert property (
    cnt_wr ##1 tick |-> !match[0] && !match[1])
    else $error("match not blocked after counter write");
  AST_MATCH_FLAG: assert property (
    match[0] |=> flags_q[IRQ_A])
    else $error("match A flag not set after match");
  AST_FLAG_CAUSE: assert property (
    $rose(flags_q[IRQ_B]) |-> $past(match[1]))
    else $error("match B flag set without real match");
  AST_IRQ_GATE: assert property (
    irq_req.overflow |-> gie && mask_q[IRQ_OVF] && flags_q[IRQ_OVF])
    else $error("overflow interrupt without enable");
  AST_ACK_CLEARS: assert property (
    irq_ack.overflow && !ovf_set |=> !flags_q[IRQ_OVF])
    else $error("overflow flag not cleared by acknowledge");
  AST_NORMAL_OVF: assert property (
    mode_normal && tick && !cnt_wr && cnt_q == TOP_MAX |=> flags_q[IRQ_OVF] && cnt_q == 16'h0000)
    else $error("normal mode overflow not flagged");

endmodule : timer16_capture_compare_regs

// *** hw/timer16_pkg.sv ***
// Purpose: Shared constants and types for the 16-bit capture/compare timer
// Assumes: Register bytes sit in the low lane of aligned 32-bit words
// Notes: One byte of register data per word, upper bits read as zero
package timer16_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_CTRL_C = 8'h08;
  localparam logic [7:0] OFF_PIN_EN = 8'h0C;
  localparam logic [7:0] OFF_CNT_L = 8'h10;
  localparam logic [7:0] OFF_CNT_H = 8'h14;
  localparam logic [7:0] OFF_CMP_A_L = 8'h18;
  localparam logic [7:0] OFF_CMP_A_H = 8'h1C;
  localparam logic [7:0] OFF_CMP_B_L = 8'h20;
  localparam logic [7:0] OFF_CMP_B_H = 8'h24;
  localparam logic [7:0] OFF_CAP_L = 8'h28;
  localparam logic [7:0] OFF_CAP_H = 8'h2C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h30;
  localparam logic [7:0] OFF_IRQ_FLAGS = 8'h34;
  localparam logic [7:0] OFF_MISC = 8'h38;

  // ----------------------------------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam int unsigned COM_A_LSB = 6;
  localparam int unsigned COM_B_LSB = 4;
  localparam int unsigned NOISE_BIT = 7;
  localparam int unsigned EDGE_BIT = 6;
  localparam int unsigned WGM_HI_LSB = 3;
  localparam int unsigned FORCE_A_BIT = 7;
  localparam int unsigned FORCE_B_BIT = 6;
  localparam int unsigned IRQ_CAP = 5;
  localparam int unsigned IRQ_B = 2;
  localparam int unsigned IRQ_A = 1;
  localparam int unsigned IRQ_OVF = 0;
  localparam int unsigned MISC_GIE_BIT = 0;
  localparam int unsigned MISC_ACMP_BIT = 1;
  localparam logic [7:0] CTRL_A_MASK = 8'hF3;
  localparam logic [7:0] CTRL_B_MASK = 8'hDF;
  localparam logic [7:0] IRQ_MASK_BITS = 8'h27;
  localparam logic [7:0] MISC_MASK = 8'h03;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] WIDE_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Timing and counting constants
  // ----------------------------------------------------------------
  localparam int unsigned FILTER_SAMPLES = 4;
  localparam int unsigned PRE_W = 10;
  localparam int unsigned DIV_8 = 8;
  localparam int unsigned DIV_64 = 64;
  localparam int unsigned DIV_256 = 256;
  localparam int unsigned DIV_1024 = 1024;
  localparam logic [15:0] TOP_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CS_STOP = 3'b000, CS_DIV1 = 3'b001, CS_DIV8 = 3'b010, CS_DIV64 = 3'b011,
    CS_DIV256 = 3'b100, CS_DIV1024 = 3'b101, CS_EXT_FALL = 3'b110, CS_EXT_RISE = 3'b111
  } clock_source_sel_t;

  typedef enum logic [1:0] {
    COM_OFF = 2'b00, COM_TOGGLE = 2'b01, COM_CLEAR = 2'b10, COM_SET = 2'b11
  } compare_output_action_t;

  typedef struct packed {
    logic [3:0] out_pin_en_b;
    logic [3:0] out_pin_en_a;
    logic wave_b;
    logic wave_a;
  } wave_pins_t;

  typedef struct packed {
    logic capture;
    logic match_b;
    logic match_a;
    logic overflow;
  } irq_lines_t;

endpackage : timer16_pkg
